// ==== core/nvmc_consts.vh ====
// Constants for the data nonvolatile array control and read path
`ifndef NVMC_CONSTS_VH
`define NVMC_CONSTS_VH

// Register select codes on the special-function register port
`define NVMC_SEL_CTRL      2'h0
`define NVMC_SEL_UNLOCK    2'h1
`define NVMC_SEL_ADDR      2'h2
`define NVMC_SEL_DATA      2'h3

// Control register field positions
`define NVMC_BIT_MEMSEL    7
`define NVMC_BIT_CFGSEL    6
`define NVMC_BIT_UNUSED    5
`define NVMC_BIT_ERASE     4
`define NVMC_BIT_ABORT     3
`define NVMC_BIT_PERMIT    2
`define NVMC_BIT_WTRIG     1
`define NVMC_BIT_RTRIG     0

// Unlock key bytes
`define NVMC_KEY_FIRST     8'h55
`define NVMC_KEY_SECOND    8'haa

// Reset values
`define NVMC_RST_BYTE      8'h00
`define NVMC_RST_UNLOCK    2'h0

// Self-timed write duration in microseconds and clock rate in kHz
`define NVMC_WRITE_TIME_US 4000
`define NVMC_CLK_KHZ       20000
`define NVMC_WRITE_CYCLES  ((`NVMC_WRITE_TIME_US * `NVMC_CLK_KHZ + 999) / 1000)

`endif

// ==== core/nvmc_array.v ====
// Byte-wide data array with a registered read port
`timescale 1ns/1ps
module nvmc_array #(
    parameter AW = 8,
    parameter DW = 8
) (
    // Clock
    input  wire          sys_clk_i,
    // Write port
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [DW-1:0] wr_data_i,
    // Read port
    input  wire          rd_en_i,
    input  wire [AW-1:0] rd_addr_i,
    output reg  [DW-1:0] rd_data_o
);
    // Storage cells, not cleared by reset
    reg [DW-1:0] mem_r [0:(1<<AW)-1];

    // Write and registered read
    always @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i) begin
            rd_data_o <= mem_r[rd_addr_i];
        end
    end
endmodule

// ==== core/nvmc_ctrl.v ====
// Control register and read path for the data nonvolatile array
`timescale 1ns/1ps
`include "nvmc_consts.vh"
module nvmc_ctrl #(
    parameter AW           = 8,
    parameter WRITE_CYCLES = `NVMC_WRITE_CYCLES
) (
    // Clock and resets
    input  wire          sys_clk_i,
    input  wire          reset_i,
    input  wire          master_clear_reset_i,
    input  wire          watchdog_timer_reset_i,
    // Special-function register port
    input  wire [1:0]    sfr_sel_i,
    input  wire          sfr_wr_i,
    input  wire          sfr_rd_i,
    input  wire [7:0]    sfr_wdata_i,
    output reg  [7:0]    sfr_rdata_o,
    // Status outputs
    output reg           write_done_flag_o,
    output reg           write_busy_o,
    output reg           row_erase_req_o,
    // Software clears the completion flag
    input  wire          write_done_clr_i
);
    // Control register fields
    reg          memory_space_select_r;
    reg          config_space_select_r;
    reg          row_erase_r;
    reg          write_abort_flag_r;
    reg          write_permit_r;
    reg          write_trig_r;
    reg          read_trig_r;
    // Address and data registers
    reg [AW-1:0] nvm_address_reg_r;
    reg [7:0]    nvm_data_reg_r;
    // Unlock sequence progress: 0 idle, 1 first key seen, 2 armed
    reg [1:0]    unlock_r;
    reg [1:0]    unlock_nxt;
    // Write timer and latched write target
    reg [31:0]   wcnt_r;
    reg [AW-1:0] waddr_r;
    reg [7:0]    wdata_r;
    // Array control
    reg          arr_wr_r;
    reg          arr_rd;
    wire [7:0]   arr_q;
    // One cycle after a read so the data register takes the array output
    reg          rd_pend_r;

    // Control register image; unused bit reads zero
    function [7:0] ctrl_img;
        input dummy;
        begin
            ctrl_img = {memory_space_select_r, config_space_select_r, 1'b0,
                        row_erase_r, write_abort_flag_r, write_permit_r,
                        write_trig_r, read_trig_r};
        end
    endfunction

    // Writes decoded
    wire ctrl_wr   = sfr_wr_i && (sfr_sel_i == `NVMC_SEL_CTRL);
    wire unlock_wr = sfr_wr_i && (sfr_sel_i == `NVMC_SEL_UNLOCK);
    wire addr_wr   = sfr_wr_i && (sfr_sel_i == `NVMC_SEL_ADDR);
    wire data_wr   = sfr_wr_i && (sfr_sel_i == `NVMC_SEL_DATA);
    // Data array only: both select bits clear
    wire data_space = !memory_space_select_r && !config_space_select_r;
    // Write start: armed, permit already set, trigger being set
    wire wr_start = ctrl_wr && sfr_wdata_i[`NVMC_BIT_WTRIG] && !write_trig_r
                    && (unlock_r == 2'h2) && write_permit_r;
    // Read start: ignored while a write runs
    wire rd_start = ctrl_wr && sfr_wdata_i[`NVMC_BIT_RTRIG] && !write_trig_r
                    && data_space;
    // Write finishes at the last timer count
    wire wr_end = write_trig_r && (wcnt_r == 32'h1);
    // Reset from outside during a write cuts it short
    wire abort_ev = (master_clear_reset_i || watchdog_timer_reset_i);

    // Unlock sequence tracker
    always @* begin
        unlock_nxt = unlock_r;
        if (unlock_wr) begin
            if (sfr_wdata_i == `NVMC_KEY_FIRST) begin
                unlock_nxt = 2'h1;
            end else if (sfr_wdata_i == `NVMC_KEY_SECOND && unlock_r == 2'h1) begin
                unlock_nxt = 2'h2;
            end else begin
                unlock_nxt = `NVMC_RST_UNLOCK;
            end
        end else if (sfr_wr_i) begin
            // Any other write breaks the sequence
            unlock_nxt = `NVMC_RST_UNLOCK;
        end
    end

    // Array read request
    always @* begin
        arr_rd = rd_start;
    end

    // Main control process
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            memory_space_select_r <= 1'b0;
            config_space_select_r <= 1'b0;
            row_erase_r           <= 1'b0;
            write_abort_flag_r    <= 1'b0;
            write_permit_r        <= 1'b0;
            write_trig_r          <= 1'b0;
            read_trig_r           <= 1'b0;
            nvm_address_reg_r     <= {AW{1'b0}};
            nvm_data_reg_r        <= `NVMC_RST_BYTE;
            unlock_r              <= `NVMC_RST_UNLOCK;
            wcnt_r                <= 32'h0;
            waddr_r               <= {AW{1'b0}};
            wdata_r               <= `NVMC_RST_BYTE;
            arr_wr_r              <= 1'b0;
            rd_pend_r             <= 1'b0;
            write_done_flag_o     <= 1'b0;
            write_busy_o          <= 1'b0;
            row_erase_req_o       <= 1'b0;
            sfr_rdata_o           <= 8'h00;
        end else if (abort_ev) begin
            // Interrupted write: flag it, keep memory select and erase bits, clear config select
            if (write_trig_r) begin
                write_abort_flag_r <= 1'b1;
            end
            config_space_select_r <= 1'b0;
            write_permit_r        <= 1'b0;
            write_trig_r          <= 1'b0;
            read_trig_r           <= 1'b0;
            nvm_address_reg_r     <= {AW{1'b0}};
            nvm_data_reg_r        <= `NVMC_RST_BYTE;
            unlock_r              <= `NVMC_RST_UNLOCK;
            wcnt_r                <= 32'h0;
            arr_wr_r              <= 1'b0;
            rd_pend_r             <= 1'b0;
            write_busy_o          <= 1'b0;
            row_erase_req_o       <= 1'b0;
        end else begin
            unlock_r  <= unlock_nxt;
            arr_wr_r  <= wr_end && !memory_space_select_r && !config_space_select_r;
            rd_pend_r <= rd_start;
            // Read trigger clears once the data register is loaded
            read_trig_r <= rd_start;
            // Control register write: triggers only settable
            if (ctrl_wr) begin
                memory_space_select_r <= sfr_wdata_i[`NVMC_BIT_MEMSEL];
                config_space_select_r <= sfr_wdata_i[`NVMC_BIT_CFGSEL];
                write_permit_r        <= sfr_wdata_i[`NVMC_BIT_PERMIT];
                write_abort_flag_r    <= sfr_wdata_i[`NVMC_BIT_ABORT];
                if (!write_trig_r) begin
                    row_erase_r <= sfr_wdata_i[`NVMC_BIT_ERASE];
                end
            end
            if (addr_wr) begin
                nvm_address_reg_r <= sfr_wdata_i[AW-1:0];
            end
            // Data register: software write or array result
            if (rd_pend_r) begin
                nvm_data_reg_r <= arr_q;
            end else if (data_wr) begin
                nvm_data_reg_r <= sfr_wdata_i;
            end
            // Write start latches target and starts timer
            if (wr_start) begin
                write_trig_r    <= 1'b1;
                waddr_r         <= nvm_address_reg_r;
                wdata_r         <= nvm_data_reg_r;
                wcnt_r          <= WRITE_CYCLES;
                write_busy_o    <= 1'b1;
                row_erase_req_o <= row_erase_r;
            end else if (write_trig_r) begin
                wcnt_r <= wcnt_r - 32'h1;
            end
            // Write completion
            if (wr_end) begin
                write_trig_r       <= 1'b0;
                write_busy_o       <= 1'b0;
                row_erase_req_o    <= 1'b0;
                row_erase_r        <= 1'b0;
                write_abort_flag_r <= 1'b0;
            end
            // Completion flag: set wins over clear
            if (wr_end) begin
                write_done_flag_o <= 1'b1;
            end else if (write_done_clr_i) begin
                write_done_flag_o <= 1'b0;
            end
            // Registered read data
            if (sfr_rd_i) begin
                case (sfr_sel_i)
                    `NVMC_SEL_CTRL:   sfr_rdata_o <= ctrl_img(1'b0);
                    `NVMC_SEL_UNLOCK: sfr_rdata_o <= 8'h00;
                    `NVMC_SEL_ADDR:   sfr_rdata_o <= nvm_address_reg_r;
                    `NVMC_SEL_DATA:   sfr_rdata_o <= nvm_data_reg_r;
                    default:          sfr_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // 256-byte data array
    nvmc_array #(
        .AW (AW),
        .DW (8)
    ) u_array (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (arr_wr_r),
        .wr_addr_i (waddr_r),
        .wr_data_i (wdata_r),
        .rd_en_i   (arr_rd),
        .rd_addr_i (nvm_address_reg_r),
        .rd_data_o (arr_q)
    );
endmodule

// ==== testbench/nvmc_properties.sv ====
// Checker properties for the nonvolatile control block
`timescale 1ns/1ps
`include "nvmc_consts.vh"
module nvmc_properties #(
    parameter WRITE_CYCLES = `NVMC_WRITE_CYCLES
) (
    input wire       sys_clk_i,
    input wire       reset_i,
    input wire       master_clear_reset_i,
    input wire       watchdog_timer_reset_i,
    input wire [1:0] sfr_sel_i,
    input wire       sfr_wr_i,
    input wire       sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    input wire [7:0] sfr_rdata_o,
    input wire       write_done_flag_o,
    input wire       write_busy_o,
    input wire       row_erase_req_o,
    input wire       write_done_clr_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    reg  [31:0] busy_cnt_r;                // Consecutive busy cycles
    wire        abort_w = master_clear_reset_i | watchdog_timer_reset_i;
    // Count how long a timed write stays busy
    always @(posedge sys_clk_i) begin
        busy_cnt_r <= (reset_i | ~write_busy_o) ? 32'h0 : busy_cnt_r + 32'h1;
    end
    // Timed write ending on its own
    sequence busy_end_s;
        $fell(write_busy_o) && !$past(abort_w);
    endsequence
    // Unused bit only matters on a control register read
    a_unused_zero:  assert property ($past(sfr_rd_i && sfr_sel_i == `NVMC_SEL_CTRL)
        |-> sfr_rdata_o[5] == 1'b0)
        else $error("unused control bit read as one");
    a_busy_needs_trig: assert property ($rose(write_busy_o) |->
        $past(sfr_wr_i && sfr_sel_i == `NVMC_SEL_CTRL && sfr_wdata_i[1]))
        else $error("write started without trigger write");
    a_busy_length:  assert property (busy_end_s |-> busy_cnt_r == WRITE_CYCLES)
        else $error("timed write length wrong");
    a_done_at_end:  assert property (busy_end_s |-> ##[0:1] write_done_flag_o)
        else $error("done flag missing after write");
    a_done_sticky:  assert property (write_done_flag_o && !write_done_clr_i
        |=> write_done_flag_o)
        else $error("done flag dropped without clear");
    a_rdata_holds:  assert property (!$past(sfr_rd_i) |-> $stable(sfr_rdata_o))
        else $error("read data changed without read");
    a_erase_in_write: assert property ($rose(row_erase_req_o) |-> write_busy_o)
        else $error("erase request outside write");
    a_reset_zero:   assert property ($fell(reset_i) |-> !write_busy_o && !write_done_flag_o
        && sfr_rdata_o == 8'h00)
        else $error("outputs not cleared by reset");
endmodule
bind nvmc_ctrl nvmc_properties #(.WRITE_CYCLES(WRITE_CYCLES)) i_props (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .master_clear_reset_i(master_clear_reset_i),
    .watchdog_timer_reset_i(watchdog_timer_reset_i), .sfr_sel_i(sfr_sel_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .write_done_flag_o(write_done_flag_o),
    .write_busy_o(write_busy_o), .row_erase_req_o(row_erase_req_o),
    .write_done_clr_i(write_done_clr_i));

// ==== testbench/nvmc_cpu_model.sv ====
// Processor core model issuing register accesses
`timescale 1ns/1ps
module nvmc_cpu_model (
    input  wire       sys_clk_i,
    output reg  [1:0] sel_o,
    output reg        wr_o,
    output reg        rd_o,
    output reg  [7:0] wdata_o
);
    initial begin
        sel_o = 2'h0; wr_o = 1'b0; rd_o = 1'b0; wdata_o = 8'h00;
    end
    // One-cycle write strobe; select and data driven with the strobe, data inverted after
    task wr(input [1:0] s, input [7:0] d);
        begin
            @(posedge sys_clk_i);
            sel_o <= s; wdata_o <= d; wr_o <= 1'b1;
            @(posedge sys_clk_i);
            wr_o <= 1'b0; wdata_o <= ~d;
        end
    endtask
    // One-cycle read strobe
    task rd(input [1:0] s);
        begin
            @(posedge sys_clk_i);
            sel_o <= s; rd_o <= 1'b1;
            @(posedge sys_clk_i);
            rd_o <= 1'b0;
        end
    endtask
endmodule

// ==== testbench/nvmc_ctrl_tb.sv ====
// Self-checking bench for the nonvolatile control block
`timescale 1ns/1ps
`include "nvmc_consts.vh"
module nvmc_ctrl_tb;
    reg clk = 0, rst = 1, master_clear_reset = 0, clr = 0, wdt = 0;
    wire [1:0] sel; wire wr, rd; wire [7:0] wd, rdata; wire done, busy, erase;
    reg [15:0] q[$];                       // Expected {mask, value}
    reg rd_d = 0; reg [15:0] e; reg [7:0] a, d;
    integer n_fail = 0, n_compared = 0, k, i;
    initial forever #25 clk = ~clk;
    nvmc_cpu_model u_cpu (.sys_clk_i(clk), .sel_o(sel), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
    nvmc_ctrl #(.WRITE_CYCLES(20)) i_dut (.sys_clk_i(clk), .reset_i(rst),
        .master_clear_reset_i(master_clear_reset), .watchdog_timer_reset_i(wdt), .sfr_sel_i(sel),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata),
        .write_done_flag_o(done), .write_busy_o(busy), .row_erase_req_o(erase),
        .write_done_clr_i(clr));
    // Compare each read result with the oldest note
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) begin
            e = q.pop_front();
            n_compared = n_compared + 1;
            if ((rdata & e[15:8]) !== e[7:0]) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t got %h exp %h", $time, rdata & e[15:8], e[7:0]);
            end
        end
    end
    task rexp(input [1:0] s, input [7:0] m, input [7:0] v);
        begin q.push_back({m, v}); u_cpu.rd(s); end
    endtask
    task chk(input x, input v);
        begin
            n_compared = n_compared + 1;
            if (x !== v) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t got %h exp %h", $time, x, v);
            end
        end
    endtask
    // Permit write first, then keys, then the same byte with the write trigger
    task unlock_go(input [7:0] b);
        begin
            u_cpu.wr(`NVMC_SEL_CTRL, b);
            u_cpu.wr(`NVMC_SEL_UNLOCK, `NVMC_KEY_FIRST);
            u_cpu.wr(`NVMC_SEL_UNLOCK, `NVMC_KEY_SECOND);
            u_cpu.wr(`NVMC_SEL_CTRL, b | 8'h02);
            @(posedge clk);
        end
    endtask
    // Wait for the timed write to end, then clear the completion flag
    task wait_done;
        begin
            for (k = 0; k < 60 && !done; k = k + 1) @(posedge clk);
            chk(done, 1'b1);
            @(posedge clk) clr <= 1;
            @(posedge clk) clr <= 0;
        end
    endtask
    task results;
        begin
            repeat (3) @(posedge clk);
            $display("compared %0d failed %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        results;
    end
    initial begin
        k = $urandom(32'hb02bfd96);
        repeat (2) @(posedge clk);
        rst <= 0;
        rexp(`NVMC_SEL_CTRL, 8'hff, 8'h00);
        rexp(`NVMC_SEL_DATA, 8'hff, 8'h00);
        $display("test reset done");
        for (i = 0; i < 2; i = i + 1) begin
            a = i ? 8'hff : $urandom; d = $urandom;
            u_cpu.wr(`NVMC_SEL_ADDR, a);
            u_cpu.wr(`NVMC_SEL_DATA, d);
            unlock_go(8'h04);
            chk(busy, 1'b1);
            wait_done;
            rexp(`NVMC_SEL_CTRL, 8'hff, 8'h04);
            u_cpu.wr(`NVMC_SEL_DATA, ~d);
            u_cpu.wr(`NVMC_SEL_CTRL, 8'h05);
            rexp(`NVMC_SEL_DATA, 8'hff, d);
            rexp(`NVMC_SEL_CTRL, 8'h01, 8'h00);
            rexp(`NVMC_SEL_DATA, 8'hff, d);
        end
        $display("test write and read done");
        u_cpu.wr(`NVMC_SEL_CTRL, 8'h06);
        repeat (2) @(posedge clk);
        chk(busy, 1'b0);
        u_cpu.wr(`NVMC_SEL_DATA, ~d);
        unlock_go(8'h04);
        repeat (3) @(posedge clk);
        chk(done, 1'b0);
        u_cpu.wr(`NVMC_SEL_CTRL, 8'h05);
        rexp(`NVMC_SEL_DATA, 8'hff, ~d);
        @(posedge clk) master_clear_reset <= 1;
        @(posedge clk) master_clear_reset <= 0;
        rexp(`NVMC_SEL_CTRL, 8'hd8, 8'h08);
        rexp(`NVMC_SEL_DATA, 8'hff, 8'h00);
        $display("test abort done");
        // Erase write ending normally clears erase and abort bits
        unlock_go(8'h1c);
        chk(erase, 1'b1);
        wait_done;
        rexp(`NVMC_SEL_CTRL, 8'h18, 8'h00);
        // Watchdog abort keeps memory select and erase bits
        unlock_go(8'h94);
        chk(erase, 1'b1);
        @(posedge clk) wdt <= 1;
        @(posedge clk) wdt <= 0;
        @(posedge clk);
        chk(busy, 1'b0);
        rexp(`NVMC_SEL_CTRL, 8'hd8, 8'h98);
        $display("test erase and watchdog done");
        results;
    end
endmodule
